// *** hdl/rcc_pkg.sv ***
package rcc_pkg;

	// ----------------------------------------
	// timing, in bit times
	// ----------------------------------------
	localparam logic [6:0] BITS_MIN = 7'h60;
	localparam logic [6:0] WAIT_BITS = 7'h08;
	localparam logic [6:0] CNT_RST = 7'h00;
	localparam logic [6:0] CNT_MAX = 7'h7f;
	localparam int TW2_BITS = 3;

	// ----------------------------------------
	// main state machine
	// ----------------------------------------
	typedef enum logic [2:0] {
		RCC_IDLE,
		RCC_REPEAT,
		RCC_RX_COLL,
		RCC_TX_COLL,
		RCC_ONE_LEFT,
		RCC_WAIT
	} rcc_state_t;

endpackage : rcc_pkg

// *** hdl/rcc_coll_ext.sv ***
`timescale 1ns/1ps
module rcc_coll_ext #(
	parameter int TW2 = rcc_pkg::TW2_BITS
) (
	// clock and control
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic tick_i,
	// segment collision, already synchronised
	input wire logic col_i,
	output logic active_o
);
	import rcc_pkg::*;

	localparam int CW = $clog2(TW2 + 1);
	localparam logic [CW-1:0] LOAD = CW'(TW2);

	logic [CW-1:0] cnt_r;
	logic [CW-1:0] cnt_nxt;

	// reload while colliding, count down afterwards in bit times
	assign cnt_nxt = col_i ? LOAD : ((tick_i && cnt_r != '0) ? cnt_r - 1'b1 : cnt_r);

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			cnt_r <= '0;
		end else if (ce_i) begin
			cnt_r <= cnt_nxt;
		end
	end

	assign active_o = col_i | (cnt_r != '0);

endmodule : rcc_coll_ext

// *** hdl/rcc_collision_ctl.sv ***
`timescale 1ns/1ps
module rcc_collision_ctl #(
	parameter int NPORTS = 13,
	parameter int TW2 = rcc_pkg::TW2_BITS
) (
	// clock, reset, enable
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// segment side, per port
	input wire logic [NPORTS-1:0] seg_rx_i,
	input wire logic [NPORTS-1:0] seg_col_i,
	output logic [NPORTS-1:0] port_tx_o,
	output logic send_jam_o,
	output logic jam_bit_o,
	// bit clock
	input wire logic bit_clk_i,
	// receive collision line, active low, two-way
	input wire logic receive_collision_line_i,
	output logic receive_collision_line_o,
	output logic receive_collision_line_oe_n_o,
	// wired-or lines, separate drive and sense, active low
	input wire logic any_transmit_collision_line_sense_n_i,
	output logic any_transmit_collision_line_drive_n_o,
	input wire logic repeater_activity_line_sense_n_i,
	output logic repeater_activity_line_drive_n_o,
	// arbitration chain, active low
	input wire logic arbitration_chain_in_n_i,
	output logic arbitration_chain_out_n_o,
	// serial bus enable, active low, and its qualifier
	input wire logic bus_serial_enable_n_i,
	output logic bus_data_ok_o,
	// state for observation
	output rcc_pkg::rcc_state_t state_o
);
	import rcc_pkg::*;

	localparam int PW = (NPORTS > 1) ? $clog2(NPORTS) : 1;
	localparam int NS = 2 * NPORTS + 6;
	// each pin's idle level, so no false activity or edge shows after reset
	localparam logic [NS-1:0] SYNC_IDLE = {5'h1f, {(2 * NPORTS + 1){1'b0}}};

	// ----------------------------------------
	// functions
	// ----------------------------------------
	// lowest index wins: port 0 is top of the chain
	function automatic logic [PW-1:0] first_set(input logic [NPORTS-1:0] v);
		logic [PW-1:0] idx;
		idx = '0;
		for (int i = NPORTS - 1; i >= 0; i--) begin
			if (v[i]) begin
				idx = PW'(i);
			end
		end
		return idx;
	endfunction : first_set

	function automatic logic [NPORTS-1:0] port_mask(input logic own, input logic [PW-1:0] p);
		logic [NPORTS-1:0] m;
		m = '0;
		m[p] = own;
		return m;
	endfunction : port_mask

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	wire [NS-1:0] async_in = {bus_serial_enable_n_i, arbitration_chain_in_n_i,
		repeater_activity_line_sense_n_i, any_transmit_collision_line_sense_n_i,
		receive_collision_line_i, bit_clk_i, seg_col_i, seg_rx_i};
	logic [NS-1:0] meta_r;
	logic [NS-1:0] sync_r;

	genvar g;
	generate
		for (g = 0; g < NS; g++) begin : g_sync
			always_ff @(posedge core_clk_i) begin
				if (rst_i) begin
					meta_r[g] <= SYNC_IDLE[g];
					sync_r[g] <= SYNC_IDLE[g];
				end else if (ce_i) begin
					meta_r[g] <= async_in[g];
					sync_r[g] <= meta_r[g];
				end
			end
		end
	endgenerate

	wire [NPORTS-1:0] rx_v = sync_r[NPORTS-1:0];
	wire [NPORTS-1:0] col_raw = sync_r[2*NPORTS-1:NPORTS];
	wire bclk_s = sync_r[2*NPORTS];
	wire rcoll_in_n = sync_r[2*NPORTS+1];
	wire anyx_in_n = sync_r[2*NPORTS+2];
	wire act_in_n = sync_r[2*NPORTS+3];
	wire chain_free = sync_r[2*NPORTS+4];
	wire ire_n = sync_r[2*NPORTS+5];

	// ----------------------------------------
	// bit tick and collision extension
	// ----------------------------------------
	logic bclk_d_r;
	wire tick = bclk_s & ~bclk_d_r;
	logic [NPORTS-1:0] col_v;

	generate
		for (g = 0; g < NPORTS; g++) begin : g_ext
			rcc_coll_ext #(
				.TW2(TW2)
			) u_ext (
				.core_clk_i(core_clk_i),
				.rst_i(rst_i),
				.ce_i(ce_i),
				.tick_i(tick),
				.col_i(col_raw[g]),
				.active_o(col_v[g])
			);
		end
	endgenerate

	// ----------------------------------------
	// registers
	// ----------------------------------------
	rcc_state_t state_r;
	rcc_state_t state_nxt;
	logic [6:0] cnt_r;
	logic [6:0] cnt_nxt;
	logic [PW-1:0] port_n_r;
	logic [PW-1:0] port_n_nxt;
	logic own_n_r;
	logic own_n_nxt;
	logic [PW-1:0] port_m_r;
	logic [PW-1:0] port_m_nxt;
	logic own_m_r;
	logic own_m_nxt;
	logic jam_r;
	logic jam_nxt;
	logic rcoll_drv_r;
	logic rcoll_drv_nxt;
	logic anyx_drv_r;
	logic anyx_drv_nxt;
	logic act_drv_r;
	logic act_drv_nxt;
	logic chain_out_n_r;
	logic chain_out_n_nxt;
	logic [NPORTS-1:0] tx_r;
	logic [NPORTS-1:0] tx_nxt;
	logic send_jam_r;
	logic send_jam_nxt;
	logic data_ok_r;
	logic data_ok_nxt;

	// ----------------------------------------
	// decode
	// ----------------------------------------
	wire [NPORTS-1:0] busy_v = rx_v | col_v;
	wire any_busy = |busy_v;
	wire any_col = |col_v;
	wire multi_col = |(col_v & (col_v - 1'b1));
	wire [NPORTS-1:0] n_mask = port_mask(own_n_r, port_n_r);
	wire [NPORTS-1:0] m_mask = port_mask(own_m_r, port_m_r);
	wire rx_n = |(rx_v & n_mask);
	wire col_n = |(col_v & n_mask);
	wire m_col = |(col_v & m_mask);
	wire m_rx = |(rx_v & m_mask);
	// own drives folded in so a standalone chip needs no loop-back to react
	wire rcoll_bus = ~rcoll_in_n | rcoll_drv_r;
	wire anyx_bus = ~anyx_in_n | anyx_drv_r;
	wire act_bus = ~act_in_n | act_drv_r;
	wire cnt_done = cnt_r >= BITS_MIN;
	// exits sampled on a tick so wired lines have settled for one bit
	wire exit_ok = cnt_done & tick;
	wire in_idle = state_r == RCC_IDLE;
	wire in_rep = state_r == RCC_REPEAT;
	wire in_rxc = state_r == RCC_RX_COLL;
	wire in_txc = state_r == RCC_TX_COLL;
	wire in_one = state_r == RCC_ONE_LEFT;
	wire in_wait = state_r == RCC_WAIT;
	wire recv_phase = in_rep | in_rxc;
	wire entering = state_nxt != state_r;
	wire jam_state_nxt = (state_nxt == RCC_RX_COLL) | (state_nxt == RCC_TX_COLL) |
		(state_nxt == RCC_ONE_LEFT);

	// ----------------------------------------
	// main state machine
	// ----------------------------------------
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			RCC_IDLE: begin
				if (act_bus || any_busy) begin
					state_nxt = RCC_REPEAT;
				end
			end
			RCC_REPEAT: begin
				if (rcoll_bus) begin
					state_nxt = RCC_RX_COLL;
				end else if (anyx_bus) begin
					state_nxt = RCC_TX_COLL;
				end else if (!act_bus && !rx_n && tick) begin
					// short frames are extended by jam
					state_nxt = cnt_done ? RCC_WAIT : RCC_RX_COLL;
				end
			end
			RCC_RX_COLL: begin
				if (anyx_bus) begin
					state_nxt = RCC_TX_COLL;
				end else if (exit_ok && !rcoll_bus && !act_bus && !rx_n && !col_n) begin
					state_nxt = RCC_WAIT;
				end
			end
			RCC_TX_COLL: begin
				if (exit_ok && !anyx_bus) begin
					if (act_bus || any_col) begin
						state_nxt = RCC_ONE_LEFT;
					end else begin
						state_nxt = RCC_WAIT;
					end
				end
			end
			RCC_ONE_LEFT: begin
				if (anyx_bus) begin
					state_nxt = RCC_TX_COLL;
				end else if (tick && !act_bus && !rcoll_bus && !m_col && !m_rx) begin
					state_nxt = RCC_WAIT;
				end
			end
			RCC_WAIT: begin
				if (tick && cnt_r >= WAIT_BITS) begin
					state_nxt = RCC_IDLE;
				end
			end
			default: begin
				state_nxt = RCC_IDLE;
			end
		endcase
	end

	// ----------------------------------------
	// bit counter and jam pattern
	// ----------------------------------------
	assign cnt_nxt = entering ? CNT_RST :
		((tick && cnt_r != CNT_MAX) ? cnt_r + 1'b1 : cnt_r);
	// first jam bit is a one, then alternating
	assign jam_nxt = (jam_state_nxt && !send_jam_r) ? 1'b1 : (tick ? ~jam_r : jam_r);
	assign send_jam_nxt = jam_state_nxt;

	// ----------------------------------------
	// port roles and arbitration
	// ----------------------------------------
	wire idle_claim = in_idle & chain_free & any_busy;
	assign own_n_nxt = in_idle ? idle_claim :
		(recv_phase && state_nxt != RCC_TX_COLL ? own_n_r : 1'b0);
	assign port_n_nxt = in_idle ? first_set(busy_v) : port_n_r;
	// colliding port re-arbitrated every cycle of transmit collision
	assign own_m_nxt = (state_nxt == RCC_TX_COLL) ? (chain_free & any_col) :
		((state_nxt == RCC_ONE_LEFT) ? own_m_r : 1'b0);
	assign port_m_nxt = (state_nxt == RCC_TX_COLL) ? first_set(col_v) : port_m_r;
	assign chain_out_n_nxt = ~(~chain_free | idle_claim | (own_n_nxt & recv_phase) |
		own_m_nxt);

	// ----------------------------------------
	// bus line drives
	// ----------------------------------------
	assign rcoll_drv_nxt = (recv_phase & col_n) | (in_one & own_m_r & m_col);
	// machine holds the line for the enforced period; ports only while not the winner
	assign anyx_drv_nxt = (state_nxt == RCC_TX_COLL && (!in_txc || !cnt_done)) |
		(in_txc & multi_col) |
		(recv_phase & |(col_v & ~n_mask)) |
		((in_txc | in_one) & |(col_v & ~m_mask));
	assign act_drv_nxt = idle_claim | (recv_phase & (rx_n | col_n) & own_n_nxt) |
		((in_txc | in_one) & own_m_nxt & (m_col | m_rx));

	// ----------------------------------------
	// transmit enables and bus data qualifier
	// ----------------------------------------
	always_comb begin
		tx_nxt = '0;
		case (state_nxt)
			RCC_REPEAT: tx_nxt = ~port_mask(own_n_nxt, port_n_nxt);
			RCC_RX_COLL: tx_nxt = ~port_mask(own_n_nxt, port_n_nxt);
			RCC_TX_COLL: tx_nxt = '1;
			RCC_ONE_LEFT: tx_nxt = ~port_mask(own_m_nxt, port_m_nxt);
			default: tx_nxt = '0;
		endcase
	end

	// serial lines meaningless from the first collision on
	assign data_ok_nxt = (state_nxt == RCC_REPEAT) & ~ire_n & ~rcoll_bus & ~anyx_bus;

	// ----------------------------------------
	// state registers
	// ----------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			state_r <= RCC_IDLE;
			cnt_r <= CNT_RST;
			bclk_d_r <= 1'b1;
			jam_r <= 1'b0;
			send_jam_r <= 1'b0;
		end else if (ce_i) begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			bclk_d_r <= bclk_s;
			jam_r <= jam_nxt;
			send_jam_r <= send_jam_nxt;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			port_n_r <= '0;
			own_n_r <= 1'b0;
			port_m_r <= '0;
			own_m_r <= 1'b0;
			chain_out_n_r <= 1'b1;
		end else if (ce_i) begin
			port_n_r <= port_n_nxt;
			own_n_r <= own_n_nxt;
			port_m_r <= port_m_nxt;
			own_m_r <= own_m_nxt;
			chain_out_n_r <= chain_out_n_nxt;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			rcoll_drv_r <= 1'b0;
			anyx_drv_r <= 1'b0;
			act_drv_r <= 1'b0;
			tx_r <= '0;
			data_ok_r <= 1'b0;
		end else if (ce_i) begin
			rcoll_drv_r <= rcoll_drv_nxt;
			anyx_drv_r <= anyx_drv_nxt;
			act_drv_r <= act_drv_nxt;
			tx_r <= tx_nxt;
			data_ok_r <= data_ok_nxt;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign port_tx_o = tx_r;
	assign send_jam_o = send_jam_r;
	assign jam_bit_o = jam_r;
	// active low line: drive a zero only while asserting, else release
	assign receive_collision_line_o = ~rcoll_drv_r;
	assign receive_collision_line_oe_n_o = ~rcoll_drv_r;
	assign any_transmit_collision_line_drive_n_o = ~anyx_drv_r;
	assign repeater_activity_line_drive_n_o = ~act_drv_r;
	assign arbitration_chain_out_n_o = chain_out_n_r;
	assign bus_data_ok_o = data_ok_r;
	assign state_o = state_r;

endmodule : rcc_collision_ctl

// *** tb/rcc_collision_ctl_monitor.sv ***
`timescale 1ns/1ps
module rcc_collision_ctl_monitor #(
	parameter int NPORTS = 13
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// watched ports
	input wire logic [NPORTS-1:0] seg_rx_i,
	input wire logic [NPORTS-1:0] seg_col_i,
	input wire logic [NPORTS-1:0] port_tx_o,
	input wire logic send_jam_o,
	input wire logic receive_collision_line_o,
	input wire logic receive_collision_line_oe_n_o,
	input wire logic any_transmit_collision_line_drive_n_o,
	input wire logic bus_data_ok_o,
	input wire rcc_pkg::rcc_state_t state_o
);
	import rcc_pkg::*;
	// ----
	// cycles spent in transmit collision
	// ----
	// 96 bit times of 64 ns, less 2.25 bits of phase slack
	localparam int TX_MIN = 1200;
	logic [11:0] tx_cyc_r;
	logic [11:0] tx_cyc_nxt;
	logic tx_sat;
	assign tx_sat = tx_cyc_r == 12'hfff;
	assign tx_cyc_nxt = (state_o != RCC_TX_COLL) ? 12'h000 :
		(tx_sat ? tx_cyc_r : tx_cyc_r + 12'h001);
	always_ff @(posedge core_clk_i) begin
		tx_cyc_r <= rst_i ? 12'h000 : tx_cyc_nxt;
	end
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	a_rcoll_drive_low: assert property (
		!receive_collision_line_oe_n_o |-> !receive_collision_line_o) else $error("rcoll driven high");
	a_rx_coll_jam: assert property (
		state_o == RCC_RX_COLL |-> send_jam_o) else $error("no jam in receive collision");
	a_tx_coll_all: assert property (
		state_o == RCC_TX_COLL |-> port_tx_o == '1 && send_jam_o) else $error("tx coll not all jam");
	a_coll_data_bad: assert property (
		state_o inside {RCC_RX_COLL, RCC_TX_COLL, RCC_ONE_LEFT} |=> !bus_data_ok_o)
		else $error("serial data trusted in collision");
	a_tx_drive_held: assert property (
		$rose(state_o == RCC_TX_COLL) |=> !any_transmit_collision_line_drive_n_o [*8])
		else $error("any tx collision not held");
	a_tx_min_len: assert property (
		$past(state_o) == RCC_TX_COLL && state_o != RCC_TX_COLL && !$past(rst_i)
		|-> tx_cyc_r >= TX_MIN) else $error("tx collision too short");
	a_wait_quiet: assert property (
		state_o == RCC_WAIT |-> port_tx_o == '0 && !send_jam_o) else $error("wait not quiet");
	a_no_early_exit: assert property (
		state_o inside {RCC_RX_COLL, RCC_TX_COLL, RCC_ONE_LEFT} && (|seg_col_i || |seg_rx_i)
		|=> state_o != RCC_WAIT) else $error("left collision while active");
endmodule : rcc_collision_ctl_monitor

bind rcc_collision_ctl rcc_collision_ctl_monitor #(.NPORTS(NPORTS)) i_rcc_collision_ctl_monitor (
	.core_clk_i(core_clk_i), .rst_i(rst_i), .seg_rx_i(seg_rx_i), .seg_col_i(seg_col_i),
	.port_tx_o(port_tx_o), .send_jam_o(send_jam_o),
	.receive_collision_line_o(receive_collision_line_o),
	.receive_collision_line_oe_n_o(receive_collision_line_oe_n_o),
	.any_transmit_collision_line_drive_n_o(any_transmit_collision_line_drive_n_o),
	.bus_data_ok_o(bus_data_ok_o), .state_o(state_o));

// *** tb/rcc_peer_model.sv ***
`timescale 1ns/1ps
module rcc_peer_model (
	// clock
	input wire logic core_clk_i,
	// peer segment events
	input wire logic peer_rx_i,
	input wire logic peer_col_i,
	input wire logic peer_txcol_i,
	// drives of the chip under test
	input wire logic dut_rc_i,
	input wire logic dut_rc_oe_n_i,
	input wire logic dut_anyx_n_i,
	input wire logic dut_act_n_i,
	// bus levels as sensed
	output logic rc_line_o,
	output logic anyx_n_o,
	output logic act_n_o,
	output logic chain_n_o,
	output logic bus_en_n_o
);
	// ----
	// peer chip, bus terminated high
	// ----
	logic claim;
	logic coll_seen_r = 1'h0;
	logic toggle_r = 1'h0;
	assign anyx_n_o = dut_anyx_n_i && !peer_txcol_i;
	// receiving port yields once any transmit collision shows
	assign claim = (peer_rx_i && anyx_n_o) || peer_txcol_i;
	assign act_n_o = dut_act_n_i && !claim;
	assign chain_n_o = !claim;
	assign rc_line_o = dut_rc_oe_n_i ? !(peer_col_i && peer_rx_i) : dut_rc_i;
	always @(posedge core_clk_i) begin
		toggle_r <= !toggle_r;
		coll_seen_r <= peer_rx_i && (coll_seen_r || peer_col_i);
	end
	// enable moves every cycle after a collision so nothing can trust it
	assign bus_en_n_o = peer_rx_i ? (coll_seen_r && toggle_r) : 1'h1;
endmodule : rcc_peer_model

// *** tb/tb_repeater_collision_control.sv ***
`timescale 1ns/1ps
module tb_repeater_collision_control;
	import rcc_pkg::*;
	// ----
	// signals and clocks
	// ----
	localparam int MIN96 = 95 * 64 / 5;
	logic core_clk = 1'h0;
	logic bit_clk = 1'h0;
	logic rst = 1'h1;
	logic [12:0] seg_rx = 13'h0000;
	logic [12:0] seg_col = 13'h0000;
	logic peer_rx = 1'h0;
	logic peer_col = 1'h0;
	logic peer_txcol = 1'h0;
	logic ce = 1'h1;
	logic jam;
	logic [12:0] port_tx;
	logic send_jam, rc_o, rc_oe_n, rc_line, anyx_s_n, anyx_d_n, act_s_n, act_d_n;
	logic chain_n, chain_out_n, bus_en_n, data_ok;
	rcc_state_t state;
	int error_cnt = 0;
	int cmp_count = 0;
	initial begin
		forever #2.5 core_clk = !core_clk;
	end
	// phase unrelated to the core clock
	initial begin
		#7;
		forever #32 bit_clk = !bit_clk;
	end
	rcc_collision_ctl #(.NPORTS(13), .TW2(3)) i_rcc_collision_ctl (
		.core_clk_i(core_clk), .rst_i(rst), .ce_i(ce), .seg_rx_i(seg_rx), .seg_col_i(seg_col),
		.port_tx_o(port_tx), .send_jam_o(send_jam), .jam_bit_o(jam), .bit_clk_i(bit_clk),
		.receive_collision_line_i(rc_line), .receive_collision_line_o(rc_o),
		.receive_collision_line_oe_n_o(rc_oe_n),
		.any_transmit_collision_line_sense_n_i(anyx_s_n),
		.any_transmit_collision_line_drive_n_o(anyx_d_n),
		.repeater_activity_line_sense_n_i(act_s_n), .repeater_activity_line_drive_n_o(act_d_n),
		.arbitration_chain_in_n_i(chain_n), .arbitration_chain_out_n_o(chain_out_n),
		.bus_serial_enable_n_i(bus_en_n), .bus_data_ok_o(data_ok), .state_o(state));
	rcc_peer_model i_rcc_peer_model (
		.core_clk_i(core_clk), .peer_rx_i(peer_rx), .peer_col_i(peer_col),
		.peer_txcol_i(peer_txcol), .dut_rc_i(rc_o), .dut_rc_oe_n_i(rc_oe_n),
		.dut_anyx_n_i(anyx_d_n), .dut_act_n_i(act_d_n), .rc_line_o(rc_line),
		.anyx_n_o(anyx_s_n), .act_n_o(act_s_n), .chain_n_o(chain_n), .bus_en_n_o(bus_en_n));
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
		end
	endtask : check
	task automatic wait_st(input rcc_state_t s, output int n);
		n = 0;
		while (state !== s && n < 4000) begin
			@(negedge core_clk);
			n++;
		end
		check("state_reached", state, s);
	endtask : wait_st
	// mode 0 short fragment, 1 data ends first, 2 data outlasts collision
	task automatic t_rx_coll(input int mode);
		int n;
		int m;
		@(posedge core_clk);
		seg_rx[2] <= 1'h1;
		wait_st(RCC_REPEAT, m);
		@(posedge core_clk);
		seg_col[2] <= 1'h1;
		wait_st(RCC_RX_COLL, n);
		check("rc_oe_n", rc_oe_n, 1'h0);
		check("rc_o", rc_o, 1'h0);
		check("send_jam", send_jam, 1'h1);
		@(posedge core_clk);
		seg_rx[2] <= (mode == 2);
		seg_col[2] <= (mode != 0);
		if (mode != 0) begin
			repeat (MIN96 + 100) @(posedge core_clk);
			seg_col[2] <= 1'h0;
		end
		if (mode == 2) begin
			repeat (200) @(negedge core_clk);
			check("rx_tail", state, RCC_RX_COLL);
			@(posedge core_clk);
			seg_rx[2] <= 1'h0;
		end
		wait_st(RCC_WAIT, m);
		check("short_len", mode != 0 || n + m + 2 >= MIN96, 1'h1);
		check("ext_min", mode != 1 || m >= 25, 1'h1);
		check("end_max", mode == 0 || m <= 70, 1'h1);
		wait_st(RCC_IDLE, n);
		$display("receive collision mode %0d done", mode);
	endtask : t_rx_coll
	task automatic t_tx_coll(input logic keep);
		int n;
		int m;
		@(posedge core_clk);
		seg_rx[2] <= 1'h1;
		wait_st(RCC_REPEAT, n);
		@(posedge core_clk);
		seg_col[5] <= 1'h1;
		wait_st(RCC_TX_COLL, n);
		check("port_tx", port_tx, 13'h1fff);
		check("anyx_d_n", anyx_d_n, 1'h0);
		check("jam_first", jam, 1'h1);
		check("chain_out_n", chain_out_n, 1'h0);
		@(posedge core_clk);
		seg_rx[2] <= 1'h0;
		repeat (keep ? MIN96 + 200 : 100) @(negedge core_clk);
		if (keep) begin
			check("one_left", state, RCC_ONE_LEFT);
			check("m_tx", port_tx[5], 1'h0);
			check("anyx_rel", anyx_d_n, 1'h1);
			check("rc_one", rc_oe_n, 1'h0);
		end
		@(posedge core_clk);
		seg_col[5] <= 1'h0;
		wait_st(RCC_WAIT, m);
		check("tx_len", keep || m + 102 >= MIN96, 1'h1);
		check("tx_end", keep ? m <= 70 : m + 102 <= MIN96 + 60, 1'h1);
		wait_st(RCC_IDLE, n);
		$display("transmit collision keep %0d done", keep);
	endtask : t_tx_coll
	// collision reported by the peer chip, on either bus line
	task automatic t_peer(input logic txcol);
		int n;
		@(posedge core_clk);
		seg_rx[2] <= txcol;
		peer_rx <= !txcol;
		wait_st(RCC_REPEAT, n);
		check("data_ok_rep", data_ok, !txcol);
		@(posedge core_clk);
		peer_txcol <= txcol;
		peer_col <= !txcol;
		wait_st(txcol ? RCC_TX_COLL : RCC_RX_COLL, n);
		check("send_jam", send_jam, 1'h1);
		check("rc_oe_n", rc_oe_n, 1'h1);
		check("data_ok", data_ok, 1'h0);
		check("act_d_n", act_d_n | !txcol, 1'h1);
		check("port_tx", port_tx | {13{!txcol}}, 13'h1fff);
		@(posedge core_clk);
		seg_rx[2] <= 1'h0;
		{peer_rx, peer_col, peer_txcol} <= 3'h0;
		wait_st(RCC_WAIT, n);
		wait_st(RCC_IDLE, n);
		$display("peer collision txcol %0d done", txcol);
	endtask : t_peer
	// enable low holds state and outputs though the segment goes quiet
	task automatic t_freeze();
		int n;
		@(posedge core_clk);
		seg_rx[2] <= 1'h1;
		wait_st(RCC_REPEAT, n);
		@(posedge core_clk);
		ce <= 1'h0;
		seg_rx[2] <= 1'h0;
		repeat (40) @(negedge core_clk);
		check("frozen_state", state, RCC_REPEAT);
		check("frozen_tx", port_tx, 13'h1ffb);
		@(posedge core_clk);
		ce <= 1'h1;
		wait_st(RCC_RX_COLL, n);
		check("frag_jam", send_jam, 1'h1);
		wait_st(RCC_IDLE, n);
		$display("clock enable freeze done");
	endtask : t_freeze
	task automatic print_verdict();
		$display("compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : print_verdict
	initial begin
		repeat (2) @(posedge core_clk);
		rst <= 1'h0;
		for (int i = 0; i < 3; i++) begin
			t_rx_coll(i);
		end
		t_tx_coll(1'h0);
		t_tx_coll(1'h1);
		t_peer(1'h0);
		t_peer(1'h1);
		t_freeze();
		print_verdict();
	end
	// about four times the expected run
	initial begin
		#250000;
		error_cnt++;
		print_verdict();
	end
endmodule : tb_repeater_collision_control
